/* File: logic/bmrs_pkg.sv */
package bmrs_pkg;
   // ==========================================
   // Register map (word index)
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_FLAGS = 4'h2;
   localparam logic [3:0] ADDR_CLKDIV = 4'h3;
   localparam logic [3:0] ADDR_SEGMENT = 4'h4;
   // ==========================================
   // Control fields
   localparam int CTL_SLEEP_BIT = 0;
   localparam int CTL_DISPLAY_BIT = 1;
   localparam int CTL_ADC_BIT = 2;
   localparam int CTL_CE_BIT = 3;
   // Flag fields
   localparam int FLG_PLL_LOSS = 7;
   localparam int FLG_PLL_RETURN = 6;
   localparam int FLG_TIMER_WAKE = 5;
   localparam int FLG_BUTTON_WAKE = 4;
   // ==========================================
   // Reset values
   localparam logic [2:0] CLKDIV_RESET = 3'h0;
   localparam logic [7:0] SEGMENT_RESET = 8'h00;
   // ==========================================
   // Timing: crystal 32768 Hz, core clock 25 MHz
   localparam int CORE_HZ = 25_000_000;
   localparam int XTAL_HZ = 32_768;
   localparam int RESET_XTAL_CYCLES = 4100;
   localparam int BATT_RESET_XTAL_CYCLES = 2;
   localparam int XTAL_DIV = CORE_HZ / XTAL_HZ;
   localparam int CPU_BATT_NUM = 7;
   // ==========================================
   typedef enum logic [2:0] {
      BMRS_RESET = 3'b000,
      BMRS_MISSION = 3'b001,
      BMRS_BROWNOUT = 3'b010,
      BMRS_DISPLAY = 3'b011,
      BMRS_SLEEP = 3'b100,
      BMRS_RELOCK = 3'b101
   } bmrs_mode_t;
endpackage : bmrs_pkg

/* File: logic/bmrs_ctl_if.sv */
`timescale 1ns/1ps
interface bmrs_ctl_if;
   logic sleep_req;
   logic display_req;
   logic [2:0] clkdiv;
   logic clear_flags_we;
   logic [3:0] clear_flags;
   logic adc_req;
   logic ce_req;
   modport regs (output sleep_req, display_req, clkdiv, clear_flags_we, clear_flags, adc_req, ce_req);
   modport core (input sleep_req, display_req, clkdiv, clear_flags_we, clear_flags, adc_req, ce_req);
endinterface : bmrs_ctl_if

/* File: logic/bmrs_sync.sv */
`timescale 1ns/1ps
module bmrs_sync (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Data
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic meta;
      logic stable;
   } bmrs_sync_state_t;
   bmrs_sync_state_t state;
   bmrs_sync_state_t next_state;
   always_comb begin
      next_state.meta = async_in;
      next_state.stable = state.meta;
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
   assign sync_out = state.stable;
endmodule : bmrs_sync

/* File: logic/bmrs_regs.sv */
`timescale 1ns/1ps
module bmrs_regs (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic soft_reset,
   input wire logic wake_low,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Block state
   input wire logic [2:0] mode,
   input wire logic pll_locked_flag,
   input wire logic wake_release,
   input wire logic [3:0] flags,
   output logic [7:0] segment_pattern,
   bmrs_ctl_if.regs ctl
);
   typedef struct packed {
      logic done;
      logic [31:0] rdata;
      logic sleep_req;
      logic display_req;
      logic adc_req;
      logic ce_req;
      logic [2:0] clkdiv;
      logic [7:0] segment;
      logic clr_we;
      logic [3:0] clr;
   } bmrs_regs_state_t;
   bmrs_regs_state_t state;
   bmrs_regs_state_t next_state;
   logic req;
   assign req = (read || write) && !state.done;
   always_comb begin
      next_state = state;
      next_state.done = req;
      next_state.clr_we = 1'b0;
      next_state.sleep_req = 1'b0;
      next_state.display_req = 1'b0;
      if (req && write) begin
         unique case (address)
            bmrs_pkg::ADDR_CONTROL: begin
               next_state.sleep_req = writedata[bmrs_pkg::CTL_SLEEP_BIT];
               next_state.display_req = writedata[bmrs_pkg::CTL_DISPLAY_BIT];
               next_state.adc_req = writedata[bmrs_pkg::CTL_ADC_BIT];
               next_state.ce_req = writedata[bmrs_pkg::CTL_CE_BIT];
            end
            bmrs_pkg::ADDR_FLAGS: begin
               next_state.clr_we = 1'b1;
               next_state.clr = writedata[7:4];
            end
            bmrs_pkg::ADDR_CLKDIV: next_state.clkdiv = writedata[2:0];
            bmrs_pkg::ADDR_SEGMENT: next_state.segment = writedata[7:0];
            default: ;
         endcase
      end
      next_state.rdata = 32'h0000_0000;
      if (req && read) begin
         unique case (address)
            bmrs_pkg::ADDR_CONTROL: next_state.rdata = {28'h000_0000, state.ce_req, state.adc_req, 2'b00};
            bmrs_pkg::ADDR_STATUS: next_state.rdata = {27'h000_0000, wake_release, pll_locked_flag, mode};
            bmrs_pkg::ADDR_FLAGS: next_state.rdata = {24'h00_0000, flags, 4'h0};
            bmrs_pkg::ADDR_CLKDIV: next_state.rdata = {29'h0000_0000, state.clkdiv};
            bmrs_pkg::ADDR_SEGMENT: next_state.rdata = {24'h00_0000, state.segment};
            default: next_state.rdata = 32'h0000_0000;
         endcase
      end
      // Defaults on reset and on wake from low
      if (soft_reset || wake_low) begin
         next_state.sleep_req = 1'b0;
         next_state.display_req = 1'b0;
         next_state.adc_req = 1'b0;
         next_state.ce_req = 1'b0;
         next_state.clkdiv = bmrs_pkg::CLKDIV_RESET;
         next_state.segment = bmrs_pkg::SEGMENT_RESET;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
   assign readdata = state.rdata;
   assign waitrequest = !state.done;
   assign segment_pattern = state.segment;
   assign ctl.sleep_req = state.sleep_req;
   assign ctl.display_req = state.display_req;
   assign ctl.clkdiv = state.clkdiv;
   assign ctl.clear_flags_we = state.clr_we;
   assign ctl.clear_flags = state.clr;
   assign ctl.adc_req = state.adc_req;
   assign ctl.ce_req = state.ce_req;
endmodule : bmrs_regs

/* File: logic/bmrs_top.sv */
// Operation
// - Battery-run keeps peripherals running
// - Battery-run with low headroom forces sleep
// - Only battery-run may request display-hold or sleep
// - Power return goes full-power after PLL settles
// - CPU clock PLL in full power, 7/8 crystal battery
// - Divider value kept, ignored in battery-run
// - No PLL lock holds converter and engine off
// - PLL lock loss clears engine counter, halts filters
// - Display-hold stops CPU, keeps and blinks segments
// - Display-hold exits on power, timer or button
// - Sleep keeps only oscillator, exits on wake events
// - Reset pin stops logic, defaults control bits
// - With power, reset lasts 4100 crystal cycles
// - Without power, reset lasts 2 crystal cycles
// - Power fail clears lock, enters battery-run
// - Power return holds reset 4100 clocks, sets lock
// - Power fail without battery drops wake, sleeps
// - Battery-run to full-power raises interrupt, keeps config
// - Wake from hold or sleep resets config
// - Watchdog activates on entering full-power
// - Request bits force mode and stop CPU immediately, in battery-run only
// - Set flags on PLL loss into battery-run and on PLL return
// - Button and timer set flags, return battery-run
`timescale 1ns/1ps
module bmrs_top #(
   parameter int RESET_CYCLES = bmrs_pkg::RESET_XTAL_CYCLES,
   parameter int XTAL_DIV = bmrs_pkg::XTAL_DIV
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Pins and analog status
   input wire logic reset_pin,
   input wire logic power_ok,
   input wire logic regulator_headroom_ok,
   input wire logic pushbutton_input,
   input wire logic wake_timer_expired,
   input wire logic pll_stable,
   input wire logic pll_cpu_tick,
   // Mode outputs
   output logic [2:0] mode,
   output logic wake_release,
   output logic pll_locked_flag,
   output logic cpu_run,
   output logic cpu_clk_en,
   output logic converter_enable,
   output logic compute_engine_enable,
   output logic fir_enable,
   output logic engine_pc_clear,
   output logic watchdog_enable,
   output logic peripherals_enable,
   output logic display_enable,
   output logic [7:0] segment_pattern,
   output logic segment_blink_en,
   output logic cpu_irq
);
   initial begin
      if (XTAL_DIV < 2 || RESET_CYCLES < 2 || RESET_CYCLES > 65535) begin
         $error("bad parameters");
      end
   end
   // ==========================================
   // Input synchronisers
   logic power_s;
   logic headroom_s;
   logic button_s;
   logic timer_s;
   logic pll_s;
   logic reset_s;
   bmrs_sync u_sync_pwr (.core_clk, .rst_n, .async_in(power_ok), .sync_out(power_s));
   bmrs_sync u_sync_hdr (.core_clk, .rst_n, .async_in(regulator_headroom_ok), .sync_out(headroom_s));
   bmrs_sync u_sync_btn (.core_clk, .rst_n, .async_in(pushbutton_input), .sync_out(button_s));
   bmrs_sync u_sync_tmr (.core_clk, .rst_n, .async_in(wake_timer_expired), .sync_out(timer_s));
   bmrs_sync u_sync_pll (.core_clk, .rst_n, .async_in(pll_stable), .sync_out(pll_s));
   bmrs_sync u_sync_rst (.core_clk, .rst_n, .async_in(reset_pin), .sync_out(reset_s));
   // ==========================================
   // State
   typedef struct packed {
      bmrs_pkg::bmrs_mode_t mode;
      logic [15:0] xdiv;
      logic xtick;
      logic [2:0] cpu_phase;
      logic [15:0] rcount;
      logic wake;
      logic pll_lock;
      logic power_d;
      logic button_d;
      logic timer_d;
      logic [3:0] flags;
      logic cpu_clk_en;
      logic conv_en;
      logic ce_en;
      logic fir_en;
      logic pc_clear;
      logic wdog;
      logic periph;
      logic disp;
      logic blink;
      logic irq;
      logic wake_low;
      logic run;
   } bmrs_state_t;
   bmrs_state_t state;
   bmrs_state_t next_state;
   bmrs_ctl_if ctl ();
   bmrs_regs u_regs (
      .core_clk,
      .rst_n,
      .soft_reset(reset_s),
      .wake_low(state.wake_low),
      .address,
      .read,
      .write,
      .writedata,
      .readdata,
      .waitrequest,
      .mode(state.mode),
      .pll_locked_flag(state.pll_lock),
      .wake_release(state.wake),
      .flags(state.flags),
      .segment_pattern,
      .ctl(ctl.regs)
   );
   logic [15:0] div_last;
   logic [15:0] rst_last;
   logic [15:0] batt_last;
   logic [2:0] div_batt;
   assign div_last = 16'(XTAL_DIV - 1);
   assign rst_last = 16'(RESET_CYCLES - 1);
   assign batt_last = 16'(bmrs_pkg::BATT_RESET_XTAL_CYCLES - 1);
   assign div_batt = 3'(bmrs_pkg::CPU_BATT_NUM);
   // ==========================================
   // Mode sequencing
   always_comb begin
      next_state = state;
      next_state.xtick = 1'b0;
      next_state.pc_clear = 1'b0;
      next_state.irq = 1'b0;
      next_state.wake_low = 1'b0;
      next_state.cpu_clk_en = 1'b0;
      next_state.power_d = power_s;
      next_state.button_d = button_s;
      next_state.timer_d = timer_s;
      // Crystal-rate enable from the core clock
      if (state.xdiv == div_last) begin
         next_state.xdiv = 16'h0000;
         next_state.xtick = 1'b1;
      end else begin
         next_state.xdiv = state.xdiv + 16'h0001;
      end
      // Hardware sets win over software clears
      if (ctl.clear_flags_we) begin
         next_state.flags = state.flags & ~ctl.clear_flags;
      end
      if (button_s && !state.button_d) begin
         next_state.flags[bmrs_pkg::FLG_BUTTON_WAKE - 4] = 1'b1;
      end
      if (timer_s && !state.timer_d) begin
         next_state.flags[bmrs_pkg::FLG_TIMER_WAKE - 4] = 1'b1;
      end
      unique case (state.mode)
         bmrs_pkg::BMRS_RESET: begin
            next_state.wake = 1'b0;
            if (state.xtick) begin
               next_state.rcount = state.rcount + 16'h0001;
               if (power_s && state.rcount >= rst_last) begin
                  next_state.mode = bmrs_pkg::BMRS_MISSION;
                  next_state.wake = 1'b1;
                  next_state.pll_lock = 1'b1;
                  next_state.wdog = 1'b1;
                  next_state.rcount = 16'h0000;
               end else if (!power_s && state.rcount >= batt_last) begin
                  next_state.mode = bmrs_pkg::BMRS_BROWNOUT;
                  next_state.wake = 1'b1;
                  next_state.rcount = 16'h0000;
               end
            end
         end
         bmrs_pkg::BMRS_MISSION: begin
            if (!power_s) begin
               next_state.pll_lock = 1'b0;
               next_state.pc_clear = 1'b1;
               if (headroom_s) begin
                  next_state.mode = bmrs_pkg::BMRS_BROWNOUT;
                  next_state.flags[bmrs_pkg::FLG_PLL_LOSS - 4] = 1'b1;
               end else begin
                  next_state.mode = bmrs_pkg::BMRS_SLEEP;
                  next_state.wake = 1'b0;
                  next_state.wake_low = 1'b1;
               end
            end
         end
         bmrs_pkg::BMRS_BROWNOUT: begin
            if (power_s && !state.power_d) begin
               next_state.mode = bmrs_pkg::BMRS_RELOCK;
               next_state.rcount = 16'h0000;
            end else if (!headroom_s) begin
               next_state.mode = bmrs_pkg::BMRS_SLEEP;
               next_state.wake = 1'b0;
               next_state.wake_low = 1'b1;
            end else if (ctl.sleep_req) begin
               next_state.mode = bmrs_pkg::BMRS_SLEEP;
               next_state.wake = 1'b0;
            end else if (ctl.display_req) begin
               next_state.mode = bmrs_pkg::BMRS_DISPLAY;
               next_state.wake = 1'b0;
            end
         end
         bmrs_pkg::BMRS_DISPLAY, bmrs_pkg::BMRS_SLEEP: begin
            if (power_s) begin
               next_state.mode = bmrs_pkg::BMRS_RELOCK;
               next_state.rcount = 16'h0000;
            end else if (((button_s && !state.button_d) || (timer_s && !state.timer_d)) && headroom_s) begin
               next_state.mode = bmrs_pkg::BMRS_BROWNOUT;
               next_state.wake = 1'b1;
               next_state.wake_low = 1'b1;
            end
         end
         bmrs_pkg::BMRS_RELOCK: begin
            if (!power_s) begin
               next_state.mode = state.wake ? bmrs_pkg::BMRS_BROWNOUT : bmrs_pkg::BMRS_SLEEP;
               next_state.rcount = 16'h0000;
            end else if (state.xtick) begin
               next_state.rcount = state.rcount + 16'h0001;
               if (state.rcount >= rst_last && pll_s) begin
                  next_state.mode = bmrs_pkg::BMRS_MISSION;
                  next_state.pll_lock = 1'b1;
                  next_state.flags[bmrs_pkg::FLG_PLL_RETURN - 4] = 1'b1;
                  next_state.irq = state.wake;
                  next_state.wake_low = !state.wake;
                  next_state.wake = 1'b1;
                  next_state.wdog = 1'b1;
                  next_state.rcount = 16'h0000;
               end
            end
         end
         default: next_state.mode = bmrs_pkg::BMRS_RESET;
      endcase
      if (reset_s) begin
         next_state.mode = bmrs_pkg::BMRS_RESET;
         next_state.wake = 1'b0;
         next_state.pll_lock = 1'b0;
         next_state.pc_clear = state.pll_lock;
         next_state.rcount = 16'h0000;
         next_state.flags = 4'h0;
         next_state.wdog = 1'b0;
      end
      // Divider value is kept but unused in battery-run
      if (next_state.mode == bmrs_pkg::BMRS_MISSION) begin
         next_state.cpu_clk_en = pll_cpu_tick;
      end else if (next_state.mode == bmrs_pkg::BMRS_BROWNOUT && state.xtick) begin
         next_state.cpu_phase = state.cpu_phase + 3'h1;
         next_state.cpu_clk_en = state.cpu_phase < div_batt;
      end
      // Enables follow the next mode
      next_state.conv_en = next_state.pll_lock && ctl.adc_req;
      next_state.ce_en = next_state.pll_lock && ctl.ce_req;
      next_state.fir_en = next_state.pll_lock;
      next_state.periph = next_state.mode == bmrs_pkg::BMRS_MISSION
         || next_state.mode == bmrs_pkg::BMRS_BROWNOUT;
      next_state.disp = next_state.periph || next_state.mode == bmrs_pkg::BMRS_DISPLAY;
      next_state.blink = next_state.mode == bmrs_pkg::BMRS_DISPLAY;
      next_state.run = next_state.wake && next_state.periph;
      if (!next_state.periph) begin
         next_state.wdog = 1'b0;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
   // ==========================================
   // Output registers
   assign mode = state.mode;
   assign wake_release = state.wake;
   assign pll_locked_flag = state.pll_lock;
   assign cpu_run = state.run;
   assign cpu_clk_en = state.cpu_clk_en;
   assign converter_enable = state.conv_en;
   assign compute_engine_enable = state.ce_en;
   assign fir_enable = state.fir_en;
   assign engine_pc_clear = state.pc_clear;
   assign watchdog_enable = state.wdog;
   assign peripherals_enable = state.periph;
   assign display_enable = state.disp;
   assign segment_blink_en = state.blink;
   assign cpu_irq = state.irq;
endmodule : bmrs_top

/* File: bench/bmrs_supply_model.sv */
`timescale 1ns/1ps
module bmrs_supply_model #(
   parameter int SETTLE = 6,
   parameter int TICK_DIV = 5
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Supply level set by the bench
   input wire logic power_ok,
   // PLL status towards the block
   output logic pll_stable,
   output logic pll_cpu_tick
);
   int settle_cnt;
   int tick_cnt;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_cnt <= 0;
         tick_cnt <= 0;
         pll_stable <= 1'b0;
         pll_cpu_tick <= 1'b0;
      end else begin
         // PLL settles after supply returns
         settle_cnt <= !power_ok ? 0 : (settle_cnt < SETTLE) ? settle_cnt + 1 : settle_cnt;
         pll_stable <= power_ok && (settle_cnt == SETTLE);
         tick_cnt <= (tick_cnt == TICK_DIV - 1) ? 0 : tick_cnt + 1;
         // No PLL clock without supply
         pll_cpu_tick <= power_ok && (tick_cnt == 0);
      end
   end
endmodule : bmrs_supply_model

/* File: bench/bmrs_monitor.sv */
`timescale 1ns/1ps
module bmrs_monitor #(
   parameter int RESET_CYCLES = 4,
   parameter int XTAL_DIV = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Pins
   input wire logic reset_pin,
   input wire logic power_ok,
   input wire logic regulator_headroom_ok,
   // Mode outputs
   input wire logic [2:0] mode,
   input wire logic wake_release,
   input wire logic pll_locked_flag,
   input wire logic cpu_run,
   input wire logic converter_enable,
   input wire logic compute_engine_enable,
   input wire logic fir_enable,
   input wire logic engine_pc_clear,
   input wire logic watchdog_enable,
   input wire logic peripherals_enable
);
   // Slack covers input synchronisers and the PLL settling after the count
   localparam int HOLD_MIN = (RESET_CYCLES - 1) * XTAL_DIV;
   localparam int HOLD_MAX = RESET_CYCLES * XTAL_DIV + 16;
   int hold_cnt;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Cycles since reset pin released or supply returned
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt <= 0;
      end else if (reset_pin || wake_release || !power_ok) begin
         hold_cnt <= 0;
      end else begin
         hold_cnt <= hold_cnt + 1;
      end
   end
   sequence s_lock_lost;
      $fell(pll_locked_flag);
   endsequence
   sequence s_engine_halted;
      ##[0:2] engine_pc_clear ##[0:1] !fir_enable;
   endsequence
   // ==========================================
   AST_NO_LOCK_ENGINES_OFF: assert property (!pll_locked_flag && !$past(pll_locked_flag) |->
      !converter_enable && !compute_engine_enable) else $error("engines on without lock");
   AST_LOCK_LOSS_HALTS: assert property (s_lock_lost |-> s_engine_halted)
      else $error("engine not halted on lock loss");
   AST_RESET_HOLD_COUNT: assert property ($rose(wake_release) && power_ok |->
      hold_cnt >= HOLD_MIN && hold_cnt <= HOLD_MAX) else $error("wake release hold count wrong");
   AST_PIN_RESET_HOLDS: assert property (reset_pin [*6] |-> mode == bmrs_pkg::BMRS_RESET && !cpu_run)
      else $error("logic active while reset pin high");
   AST_LOW_HEADROOM_SLEEPS: assert property (mode == bmrs_pkg::BMRS_BROWNOUT && !regulator_headroom_ok
      && !power_ok && !reset_pin |-> ##[1:6] mode == bmrs_pkg::BMRS_SLEEP) else $error("no sleep on low headroom");
   AST_BATTERY_KEEPS_PERIPH: assert property (mode == bmrs_pkg::BMRS_BROWNOUT && $past(mode) == mode
      |-> peripherals_enable) else $error("peripherals off in battery-run");
   AST_SLEEP_QUIET: assert property (mode == bmrs_pkg::BMRS_SLEEP && $past(mode) == mode
      |-> !cpu_run && !peripherals_enable) else $error("activity in sleep");
   AST_DISPLAY_NO_CPU: assert property (mode == bmrs_pkg::BMRS_DISPLAY && $past(mode) == mode |-> !cpu_run)
      else $error("processor runs in display-hold");
   AST_WATCHDOG_MISSION: assert property (mode == bmrs_pkg::BMRS_MISSION && $past(mode) == mode
      |-> watchdog_enable) else $error("watchdog off in full power");
   AST_POWER_FAIL_UNLOCKS: assert property ($fell(power_ok) |-> ##[1:6] !pll_locked_flag)
      else $error("lock kept after power fail");
endmodule : bmrs_monitor

/* File: bench/battery_mode_reset_sequencer_tb.sv */
`timescale 1ns/1ps
module battery_mode_reset_sequencer_tb;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic reset_pin = 1'b0;
   logic power_ok = 1'b1;
   logic regulator_headroom_ok = 1'b1;
   logic pushbutton_input = 1'b0;
   logic wake_timer_expired = 1'b0;
   logic [31:0] readdata, rd;
   logic [7:0] segment_pattern;
   logic [2:0] mode;
   logic waitrequest, pll_stable, pll_cpu_tick, wake_release, pll_locked_flag, cpu_run, cpu_clk_en;
   logic converter_enable, compute_engine_enable, fir_enable, engine_pc_clear, watchdog_enable;
   logic peripherals_enable, display_enable, segment_blink_en, cpu_irq;
   int n_errors = 0;
   int checks = 0;
   int irq_seen = 0, waited = 0, pulses = 0;
   bmrs_supply_model u_bmrs_supply_model (.*);
   bmrs_top #(.RESET_CYCLES(4), .XTAL_DIV(4)) u_bmrs_top (.*);
   initial forever #20 core_clk = ~core_clk;
   always @(posedge core_clk) if (cpu_irq === 1'b1) irq_seen++;
   // ==========================================
   task automatic tally_and_finish();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Hold request until waitrequest low, then idle
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int i;
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      for (i = 0; i < 50; i++) begin
         @(posedge core_clk);
         if (waitrequest === 1'b0) break;
      end
      if (i == 50) begin
         n_errors++;
         tally_and_finish();
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge core_clk);
   endtask : bus
   task automatic rd_check(input string what, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      check(what, rd & m, e);
   endtask : rd_check
   // Let outputs settle after the mode
   task automatic wait_mode(input logic [2:0] m);
      int i;
      for (i = 0; i < 400; i++) begin
         @(posedge core_clk);
         if (mode === m) break;
      end
      if (i == 400) begin
         n_errors++;
         tally_and_finish();
      end
      waited = i;
      repeat (3) @(posedge core_clk);
   endtask : wait_mode
   // ==========================================
   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      wait_mode(bmrs_pkg::BMRS_MISSION);
      check("wake", wake_release, 1'b1);
      check("lock", pll_locked_flag, 1'b1);
      check("wdog", watchdog_enable, 1'b1);
      rd_check("clkdiv", bmrs_pkg::ADDR_CLKDIV, 32'h0000_0007, 32'h0000_0000);
      rd_check("segment", bmrs_pkg::ADDR_SEGMENT, 32'h0000_00FF, 32'h0000_0000);
      rd_check("status", bmrs_pkg::ADDR_STATUS, 32'h0000_0007, 32'h0000_0001);
      bus(1'b1, 4'hF, 32'hFFFF_FFFF);
      rd_check("unmapped", 4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
      bus(1'b1, bmrs_pkg::ADDR_CLKDIV, 32'h0000_0005);
      bus(1'b1, bmrs_pkg::ADDR_SEGMENT, 32'h0000_00A5);
      // Sleep request refused outside battery-run; converter and engine bits taken
      bus(1'b1, bmrs_pkg::ADDR_CONTROL, 32'h0000_000D);
      repeat (4) @(posedge core_clk);
      check("mode", mode, bmrs_pkg::BMRS_MISSION);
      check("adc", converter_enable, 1'b1);
      check("ce", compute_engine_enable, 1'b1);
      power_ok <= 1'b0;
      wait_mode(bmrs_pkg::BMRS_BROWNOUT);
      check("lock", pll_locked_flag, 1'b0);
      check("adc", converter_enable, 1'b0);
      check("ce", compute_engine_enable, 1'b0);
      check("fir", fir_enable, 1'b0);
      check("periph", peripherals_enable, 1'b1);
      check("display", display_enable, 1'b1);
      rd_check("loss", bmrs_pkg::ADDR_FLAGS, 32'h0000_0080, 32'h0000_0080);
      rd_check("clkdiv", bmrs_pkg::ADDR_CLKDIV, 32'h0000_0007, 32'h0000_0005);
      bus(1'b1, bmrs_pkg::ADDR_FLAGS, 32'h0000_00F0);
      rd_check("cleared", bmrs_pkg::ADDR_FLAGS, 32'h0000_00F0, 32'h0000_0000);
      // 64 crystal ticks: 7 of 8 reach the processor
      repeat (256) begin
         @(posedge core_clk);
         if (cpu_clk_en === 1'b1) pulses++;
      end
      check("cpu rate", pulses >= 55 && pulses <= 57, 1'b1);
      bus(1'b1, bmrs_pkg::ADDR_CONTROL, 32'h0000_0002);
      wait_mode(bmrs_pkg::BMRS_DISPLAY);
      check("cpu", cpu_run, 1'b0);
      check("seg", segment_pattern, 8'hA5);
      check("blink", segment_blink_en, 1'b1);
      repeat (20) @(posedge core_clk);
      check("held", mode, bmrs_pkg::BMRS_DISPLAY);
      pushbutton_input <= 1'b1;
      wait_mode(bmrs_pkg::BMRS_BROWNOUT);
      pushbutton_input <= 1'b0;
      rd_check("button", bmrs_pkg::ADDR_FLAGS, 32'h0000_0010, 32'h0000_0010);
      rd_check("ctl dflt", bmrs_pkg::ADDR_CONTROL, 32'h0000_000C, 32'h0000_0000);
      bus(1'b1, bmrs_pkg::ADDR_FLAGS, 32'h0000_00F0);
      bus(1'b1, bmrs_pkg::ADDR_CONTROL, 32'h0000_0001);
      wait_mode(bmrs_pkg::BMRS_SLEEP);
      check("periph", peripherals_enable, 1'b0);
      wake_timer_expired <= 1'b1;
      wait_mode(bmrs_pkg::BMRS_BROWNOUT);
      wake_timer_expired <= 1'b0;
      rd_check("timer", bmrs_pkg::ADDR_FLAGS, 32'h0000_0020, 32'h0000_0020);
      regulator_headroom_ok <= 1'b0;
      wait_mode(bmrs_pkg::BMRS_SLEEP);
      check("wake", wake_release, 1'b0);
      regulator_headroom_ok <= 1'b1;
      repeat (20) @(posedge core_clk);
      check("stay", mode, bmrs_pkg::BMRS_SLEEP);
      power_ok <= 1'b1;
      wait_mode(bmrs_pkg::BMRS_MISSION);
      check("lock", pll_locked_flag, 1'b1);
      power_ok <= 1'b0;
      wait_mode(bmrs_pkg::BMRS_BROWNOUT);
      bus(1'b1, bmrs_pkg::ADDR_CLKDIV, 32'h0000_0003);
      irq_seen = 0;
      power_ok <= 1'b1;
      wait_mode(bmrs_pkg::BMRS_MISSION);
      check("irq", irq_seen > 0, 1'b1);
      rd_check("kept", bmrs_pkg::ADDR_CLKDIV, 32'h0000_0007, 32'h0000_0003);
      rd_check("return", bmrs_pkg::ADDR_FLAGS, 32'h0000_0040, 32'h0000_0040);
      reset_pin <= 1'b1;
      repeat (10) @(posedge core_clk);
      check("reset", mode, bmrs_pkg::BMRS_RESET);
      power_ok <= 1'b0;
      repeat (10) @(posedge core_clk);
      reset_pin <= 1'b0;
      wait_mode(bmrs_pkg::BMRS_BROWNOUT);
      check("batt hold", waited <= 16, 1'b1);
      rd_check("clkdiv", bmrs_pkg::ADDR_CLKDIV, 32'h0000_0007, 32'h0000_0000);
      tally_and_finish();
   end
endmodule : battery_mode_reset_sequencer_tb
bind bmrs_top bmrs_monitor #(.RESET_CYCLES(RESET_CYCLES), .XTAL_DIV(XTAL_DIV)) u_bmrs_monitor (.*);
